// ===== hw/intc_pkg.sv
// shared constants and types for the prioritized interrupt controller
package intc_pkg;
  localparam int DATA_W            = 16;
  localparam int ADDR_W            = 4;
  localparam int PRIO_W            = 3;
  localparam int LEVEL_W           = 4;
  localparam int VEC_W             = 8;
  localparam int TRAP_W            = 4;
  localparam int MAX_SRC           = 16;
  localparam int SRC_PER_PRIO_REG  = 4;
  localparam int PRIO_FIELD_STRIDE = 4;
  localparam int NUM_PRIO_REGS     = MAX_SRC / SRC_PER_PRIO_REG;

  // register offsets (word index on the plain register port)
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO   = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL_THREE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL_FOUR  = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_FLAGS      = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ENABLE     = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_PRIO0      = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_TAKEN      = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'hB;
  localparam logic [ADDR_W-1:0] OFS_CORE_CTRL  = 4'hC;

  // field positions
  localparam int NEST_DIS_POS   = 15;
  localparam int GIE_POS        = 15;
  localparam int DMA_TRAP_POS   = 0;
  localparam int LOOP_TRAP_POS  = 1;
  localparam int SOFT_TRAP_POS  = 0;
  localparam int LEVEL_LO_POS   = 5;
  localparam int LEVEL_TOP_POS  = 3;
  localparam int NEW_LEVEL_POS  = 8;

  // values after reset and fixed levels
  localparam logic [VEC_W-1:0]   VECTOR_BASE  = 8'h08;
  localparam logic [LEVEL_W-1:0] NEST_LEVEL   = 4'h7;
  localparam logic [LEVEL_W-1:0] RST_LEVEL    = 4'h0;
  localparam logic [PRIO_W-1:0]  RST_PRIO     = 3'h4;
  localparam logic [DATA_W-1:0]  RST_WORD     = 16'h0000;
  localparam logic               RST_GIE      = 1'b1;

  typedef logic [PRIO_W-1:0]  prio_t;
  typedef logic [LEVEL_W-1:0] level_t;
  typedef logic [DATA_W-1:0]  word_t;
endpackage

// ===== hw/arb_if.sv
// bundle between the controller and its priority arbiter
`timescale 1ns/1ps
interface arb_if #(parameter int N = 16);
  import intc_pkg::*;
  logic [N-1:0]         eligible;
  prio_t [N-1:0]        prio;
  logic                 found;
  logic [$clog2(N)-1:0] index;
  prio_t                level;
  modport ctrl (output eligible, prio, input found, index, level);
  modport arb  (input eligible, prio, output found, index, level);
endinterface

// ===== hw/prio_arbiter.sv
// picks the highest assigned priority among eligible sources
`timescale 1ns/1ps
module prio_arbiter (
  arb_if.arb pick
);
  import intc_pkg::*;
  localparam int N  = $bits(pick.eligible);
  localparam int IW = $bits(pick.index);

  // strict compare: an equal level never displaces a lower index
  always_comb begin
    pick.found = 1'b0;
    pick.index = '0;
    pick.level = '0;
    for (int i = 0; i < N; i++) begin
      if (pick.eligible[i] && (!pick.found || pick.prio[i] > pick.level)) begin
        pick.found = 1'b1;
        pick.index = IW'(i);
        pick.level = pick.prio[i];
      end
    end
  end
endmodule

// ===== hw/pin_edge_sync.sv
// two-stage synchroniser and edge detector for external request pins
`timescale 1ns/1ps
module pin_edge_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] falling,
  output logic      [W-1:0] edge_seen
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] last;
  logic [2:0]   primed;

  // only the second stage and its one-cycle-delayed copy (last) feed the edge compare
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta   <= '0;
      stable <= '0;
      last   <= '0;
      primed <= 3'h0;
    end else begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
      primed <= {primed[1:0], 1'b1};
    end
  end

  // polarity chosen per pin by software; edges stay muted until last
  // holds a real sample, else a pin idling high fakes a rise at reset
  assign edge_seen = primed[2] ?
                     ((last & ~stable & falling) | (~last & stable & ~falling))
                     : '0;
endmodule

// ===== hw/prio_intc.sv
// prioritized interrupt controller: flags, enables, levels, vector latch
`timescale 1ns/1ps

// Notes on behaviour
// - control one: nesting disable and trap flags
// - control two: global enable, pin edge polarity
// - control three: DMA and loop-stack trap flags
// - control four: software hard trap bit
// - source flag set by event, cleared by software
// - per-source enable bit masks each request
// - per-source writable three-bit priority, eight levels
// - taken request latches vector and new level
// - new level equals serviced request's priority
// - sources in vector order, first at vector 8
// - status bits 7:5 show and set level
// - level top bit read-only to software
module prio_intc
  import intc_pkg::*;
#(
  parameter int NUM_SRC = 16,
  parameter int NUM_EXT = 2
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [DATA_W-1:0]    reg_rdata,
  input  wire logic [NUM_EXT-1:0]   ext_irq_pin,
  input  wire logic [NUM_SRC-NUM_EXT-1:0] periph_evt,
  input  wire logic [TRAP_W-1:0]    trap_evt,
  input  wire logic                 dma_trap_evt,
  input  wire logic                 loop_ovf_evt,
  input  wire logic                 irq_ack,
  input  wire logic                 level_load,
  input  wire logic [LEVEL_W-1:0]   level_value,
  output logic                      irq_req,
  output logic      [VEC_W-1:0]     irq_vector,
  output logic      [LEVEL_W-1:0]   irq_level,
  output logic                      trap_req,
  output logic      [LEVEL_W-1:0]   current_cpu_level
);
  localparam word_t SRC_MASK  = word_t'((32'h1 << NUM_SRC) - 1);
  localparam word_t EXT_MASK  = word_t'((32'h1 << NUM_EXT) - 1);
  localparam word_t TRAP_MASK = word_t'((32'h1 << TRAP_W) - 1);
  localparam int    VEC_FIRST = VECTOR_BASE;
  localparam int    VEC_LAST  = VECTOR_BASE + NUM_SRC - 1;

  // refuse counts that the priority words or the pin field cannot hold
  if (NUM_SRC > MAX_SRC || NUM_SRC % SRC_PER_PRIO_REG != 0 ||
      NUM_EXT < 1 || NUM_EXT >= NUM_SRC ||
      NUM_EXT > GIE_POS) begin : g_bad_counts
    $error("prio_intc: unsupported source counts");
  end

  // register state
  word_t        global_ctrl_one;
  word_t        global_ctrl_two;
  word_t        global_ctrl_three;
  logic         soft_hard_trap_flag;
  word_t        request_flag_regs;
  word_t        source_enable_regs;
  prio_t        source_priority_regs [MAX_SRC];
  logic [VEC_W-1:0]   taken_vector_number;
  logic [LEVEL_W-1:0] new_cpu_level;

  // address decode
  wire wr_one   = reg_wr && reg_addr == OFS_CTRL_ONE;
  wire wr_two   = reg_wr && reg_addr == OFS_CTRL_TWO;
  wire wr_three = reg_wr && reg_addr == OFS_CTRL_THREE;
  wire wr_four  = reg_wr && reg_addr == OFS_CTRL_FOUR;
  wire wr_flags = reg_wr && reg_addr == OFS_FLAGS;
  wire wr_en    = reg_wr && reg_addr == OFS_ENABLE;
  wire wr_stat  = reg_wr && reg_addr == OFS_STATUS;

  // control fields
  wire nesting_disable   = global_ctrl_one[NEST_DIS_POS];
  wire global_irq_enable = global_ctrl_two[GIE_POS];
  wire [NUM_EXT-1:0] edge_falling = global_ctrl_two[NUM_EXT-1:0];
  wire cpu_level_top_bit = current_cpu_level[LEVEL_TOP_POS];

  // external pins cross into sys_clk before edge detection
  logic [NUM_EXT-1:0] ext_edge;
  pin_edge_sync #(.W(NUM_EXT)) u_pin_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin       (ext_irq_pin),
    .falling   (edge_falling),
    .edge_seen (ext_edge)
  );

  // source order: external pins first, then peripherals
  wire word_t src_set = word_t'({periph_evt, ext_edge});

  // hardware set beats a same-cycle software clear
  wire word_t flag_clr   = wr_flags ? reg_wdata : '0;
  wire word_t next_flags = ((request_flag_regs & ~flag_clr) | src_set)
                           & SRC_MASK;

  wire word_t trap_set   = word_t'(trap_evt) & TRAP_MASK;
  wire word_t trap_clr   = wr_one ? (reg_wdata & TRAP_MASK) : '0;
  wire word_t next_one   = {wr_one ? reg_wdata[NEST_DIS_POS] : nesting_disable,
                            global_ctrl_one[NEST_DIS_POS-1:0]
                            & ~trap_clr[NEST_DIS_POS-1:0]
                            | trap_set[NEST_DIS_POS-1:0]};

  wire word_t three_set  = word_t'({loop_ovf_evt, dma_trap_evt});
  wire word_t three_clr  = wr_three ? reg_wdata : '0;
  wire word_t next_three = ((global_ctrl_three & ~three_clr) | three_set)
                           & word_t'(16'h0003);

  wire word_t next_two   = (reg_wdata & EXT_MASK)
                           | word_t'({reg_wdata[GIE_POS], 15'h0000});

  // global control and flag registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_ctrl_one     <= RST_WORD;
      global_ctrl_two     <= word_t'({RST_GIE, 15'h0000});
      global_ctrl_three   <= RST_WORD;
      soft_hard_trap_flag <= 1'b0;
      request_flag_regs   <= RST_WORD;
      source_enable_regs  <= RST_WORD;
    end else begin
      global_ctrl_one   <= next_one;
      global_ctrl_three <= next_three;
      request_flag_regs <= next_flags;
      if (wr_two)
        global_ctrl_two <= next_two;
      if (wr_four)
        soft_hard_trap_flag <= reg_wdata[SOFT_TRAP_POS];
      if (wr_en)
        source_enable_regs <= reg_wdata & SRC_MASK;
    end
  end

  // per-source priority storage, eligibility and read nibbles
  arb_if #(.N(NUM_SRC)) pick ();
  word_t prio_word [NUM_PRIO_REGS];

  for (genvar e = 0; e < MAX_SRC; e++) begin : g_src
    localparam logic [ADDR_W-1:0] PRIO_OFS =
      ADDR_W'(OFS_PRIO0 + e / SRC_PER_PRIO_REG);
    localparam int FIELD = (e % SRC_PER_PRIO_REG) * PRIO_FIELD_STRIDE;
    if (e < NUM_SRC) begin : g_live
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
          source_priority_regs[e] <= RST_PRIO;
        else if (reg_wr && reg_addr == PRIO_OFS)
          source_priority_regs[e] <= reg_wdata[FIELD +: PRIO_W];
      end
      assign pick.prio[e]     = source_priority_regs[e];
      assign pick.eligible[e] = request_flag_regs[e] &&
                                source_enable_regs[e] &&
                                global_irq_enable &&
                                level_t'(source_priority_regs[e])
                                > current_cpu_level;
    end else begin : g_none
      assign source_priority_regs[e] = '0;
    end
    assign prio_word[e / SRC_PER_PRIO_REG][FIELD +: PRIO_FIELD_STRIDE] =
      level_t'(source_priority_regs[e]);
  end

  prio_arbiter u_arbiter (
    .pick (pick.arb)
  );

  // presented request, one cycle behind the arbiter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req    <= 1'b0;
      irq_vector <= VECTOR_BASE;
      irq_level  <= RST_LEVEL;
    end else begin
      irq_req    <= pick.found;
      irq_vector <= VECTOR_BASE + VEC_W'(pick.index);
      irq_level  <= level_t'(pick.level);
    end
  end

  // taking a request: latch vector and raise the cpu level
  wire take = irq_ack && irq_req;
  wire level_t ack_level = nesting_disable ? NEST_LEVEL : irq_level;
  wire level_t sw_level  = {cpu_level_top_bit,
                            reg_wdata[LEVEL_LO_POS +: PRIO_W]};
  // a core load wins over a take, which wins over software
  wire level_t next_level = level_load ? level_value :
                            take       ? ack_level :
                            wr_stat    ? sw_level : current_cpu_level;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_vector_number <= '0;
      new_cpu_level       <= RST_LEVEL;
      current_cpu_level   <= RST_LEVEL;
    end else begin
      if (take) begin
        taken_vector_number <= irq_vector;
        new_cpu_level       <= irq_level;
      end
      current_cpu_level <= next_level;
    end
  end

  // trap line: any trap flag or the software hard trap
  wire trap_any = |global_ctrl_one[TRAP_W-1:0] ||
                  |global_ctrl_three || soft_hard_trap_flag;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      trap_req <= 1'b0;
    else
      trap_req <= trap_any;
  end

  // read map; unmapped offsets read zero
  word_t read_map [1 << ADDR_W];
  for (genvar a = 0; a < (1 << ADDR_W); a++) begin : g_map
    if (a == OFS_CTRL_ONE) begin : g_one
      assign read_map[a] = global_ctrl_one;
    end else if (a == OFS_CTRL_TWO) begin : g_two
      assign read_map[a] = global_ctrl_two;
    end else if (a == OFS_CTRL_THREE) begin : g_three
      assign read_map[a] = global_ctrl_three;
    end else if (a == OFS_CTRL_FOUR) begin : g_four
      assign read_map[a] = word_t'(soft_hard_trap_flag);
    end else if (a == OFS_FLAGS) begin : g_flags
      assign read_map[a] = request_flag_regs;
    end else if (a == OFS_ENABLE) begin : g_en
      assign read_map[a] = source_enable_regs;
    end else if (a >= OFS_PRIO0 && a < OFS_PRIO0 + NUM_PRIO_REGS) begin : g_pr
      assign read_map[a] = prio_word[a - OFS_PRIO0];
    end else if (a == OFS_TAKEN) begin : g_taken
      assign read_map[a] = word_t'({new_cpu_level,
                                    taken_vector_number});
    end else if (a == OFS_STATUS) begin : g_stat
      assign read_map[a] = word_t'({current_cpu_level[PRIO_W-1:0],
                                    5'h00});
    end else if (a == OFS_CORE_CTRL) begin : g_core
      assign read_map[a] = word_t'(cpu_level_top_bit) << LEVEL_TOP_POS;
    end else begin : g_zero
      assign read_map[a] = RST_WORD;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= RST_WORD;
    else
      reg_rdata <= reg_rd ? read_map[reg_addr] : RST_WORD;
  end

  // checks share one clock and stay quiet while reset is low
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence take_s;
    irq_ack && irq_req && !level_load;
  endsequence

  sequence status_write_s;
    wr_stat && !level_load && !take;
  endsequence

  nest_level_a: assert property (
    take_s ##0 nesting_disable |=> current_cpu_level == NEST_LEVEL)
    else $error("nesting disable did not pin level");

  gie_read_a: assert property (
    reg_rd && reg_addr == OFS_CTRL_TWO
    |=> reg_rdata[GIE_POS] == $past(global_irq_enable))
    else $error("global enable read back wrong");

  dma_trap_a: assert property (
    dma_trap_evt |=> global_ctrl_three[DMA_TRAP_POS] ##1 trap_req)
    else $error("dma trap not recorded");

  soft_trap_a: assert property (
    wr_four && reg_wdata[SOFT_TRAP_POS] |-> ##[1:2] trap_req)
    else $error("software hard trap not raised");

  flag_sticky_a: assert property (
    request_flag_regs[0] && !(wr_flags && reg_wdata[0])
    |=> request_flag_regs[0])
    else $error("flag lost without software clear");

  flag_set_a: assert property (
    periph_evt[0] |=> request_flag_regs[NUM_EXT])
    else $error("peripheral event not flagged");

  enable_mask_a: assert property (
    source_enable_regs == '0 |=> !irq_req)
    else $error("request offered with all sources masked");

  taken_latch_a: assert property (
    take |=> taken_vector_number == $past(irq_vector)
             && new_cpu_level == $past(irq_level))
    else $error("taken vector not latched");

  new_level_a: assert property (
    take_s ##0 !nesting_disable |=> current_cpu_level == $past(irq_level))
    else $error("cpu level not raised to request level");

  vector_range_a: assert property (
    irq_req |-> irq_vector >= VEC_FIRST && irq_vector <= VEC_LAST)
    else $error("vector outside source range");

  status_write_a: assert property (
    status_write_s |=> current_cpu_level[PRIO_W-1:0]
                       == $past(reg_wdata[LEVEL_LO_POS +: PRIO_W]))
    else $error("status write did not set level");

  top_bit_ro_a: assert property (
    reg_wr && !level_load && !take |=> $stable(cpu_level_top_bit))
    else $error("software changed level top bit");

  level_gate_a: assert property (
    irq_req |-> irq_level > $past(current_cpu_level) && $past(global_irq_enable))
    else $error("request offered at or below cpu level");

  // field writes, read-back of latched state, trap line, pin flag and core level loads
  prio_write_a: assert property (
    reg_wr && reg_addr == OFS_PRIO0
    |=> source_priority_regs[0] == $past(reg_wdata[PRIO_W-1:0]))
    else $error("priority field not written");

  taken_read_a: assert property (
    reg_rd && reg_addr == OFS_TAKEN
    |=> reg_rdata == word_t'({$past(new_cpu_level),
                              $past(taken_vector_number)}))
    else $error("taken register read back wrong");

  trap_line_a: assert property (
    (|global_ctrl_one[TRAP_W-1:0]) |=> trap_req)
    else $error("trap flag did not raise trap line");

  pin_flag_a: assert property (
    ext_edge[0] |=> request_flag_regs[0])
    else $error("pin edge not flagged at source zero");

  core_load_a: assert property (
    level_load |=> current_cpu_level == $past(level_value))
    else $error("core level load ignored");

  top_read_a: assert property (
    reg_rd && reg_addr == OFS_CORE_CTRL
    |=> reg_rdata == (word_t'($past(cpu_level_top_bit)) << LEVEL_TOP_POS))
    else $error("level top bit read back wrong");
endmodule

// ===== testbench/core_model.sv
// behavioural processor core: takes offered requests, restores level
`timescale 1ns/1ps
module core_model
  import intc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  input  wire logic       ret_req,
  input  wire level_t     ret_level,
  output logic            irq_ack,
  output logic            level_load,
  output level_t          level_value
);
  logic [3:0] wait_cnt;
  logic [1:0] hold_off;
  wire        can_take = ack_en && irq_req && hold_off == 2'h0;
  wire        fire     = can_take && wait_cnt == ack_delay;

  // a take is followed by a pause: the request may stand one more
  // cycle while it still reflects the old level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      hold_off <= 2'h0;
      irq_ack  <= 1'b0;
    end else begin
      irq_ack  <= fire;
      wait_cnt <= (can_take && !fire) ? wait_cnt + 4'h1 : 4'h0;
      hold_off <= fire ? 2'h3 : (hold_off != 2'h0 ? hold_off - 2'h1 : 2'h0);
    end
  end

  // level lines carry the inverse of the last value while not loading
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_load  <= 1'b0;
      level_value <= 4'hF;
    end else begin
      level_load  <= ret_req;
      level_value <= ret_req ? ret_level : ~ret_level;
    end
  end
endmodule

// ===== testbench/tb_prioritized_interrupt_controller.sv
// self-checking bench for the prioritized interrupt controller
`timescale 1ns/1ps
module tb_prioritized_interrupt_controller;
  import intc_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [3:0] a;
    word_t      d;
  } row_t;
  logic        sys_clk, rst_n, reg_wr, reg_rd, irq_ack, irq_req;
  logic        dma_trap_evt, loop_ovf_evt, level_load, trap_req;
  logic        ack_en, ret_req;
  logic [3:0]  reg_addr, trap_evt, ack_delay;
  word_t       reg_wdata, reg_rdata;
  logic [1:0]  ext_irq_pin;
  logic [13:0] periph_evt;
  logic [7:0]  irq_vector;
  level_t      level_value, irq_level, current_cpu_level, ret_level;
  int          err_count, n_checks, cyc_count;
  // reads carry the expected word, writes the data
  localparam row_t ROWS [38] = '{
    '{0,4'h0,16'h0000}, '{0,4'h1,16'h8000}, '{0,4'h2,16'h0000},
    '{0,4'h3,16'h0000}, '{0,4'h4,16'h0000}, '{0,4'h5,16'h0000},
    '{0,4'h6,16'h4444}, '{0,4'h7,16'h4444}, '{0,4'h8,16'h4444},
    '{0,4'h9,16'h4444}, '{0,4'hA,16'h0000}, '{0,4'hB,16'h0000},
    '{0,4'hC,16'h0000}, '{0,4'hD,16'h0000},
    '{1,4'h5,16'hFFFF}, '{0,4'h5,16'hFFFF}, '{1,4'h6,16'hFFFF},
    '{0,4'h6,16'h7777}, '{1,4'hA,16'hFFFF}, '{0,4'hA,16'h0000},
    '{1,4'hC,16'hFFFF}, '{0,4'hC,16'h0000}, '{1,4'h0,16'h8000},
    '{0,4'h0,16'h8000}, '{1,4'h3,16'h0001}, '{0,4'h3,16'h0001},
    '{1,4'h1,16'h8003}, '{0,4'h1,16'h8003}, '{1,4'hB,16'h00E0},
    '{0,4'hB,16'h00E0}, '{1,4'hD,16'hFFFF}, '{0,4'hD,16'h0000},
    '{1,4'h0,16'h0000}, '{1,4'h3,16'h0000}, '{1,4'h1,16'h8000},
    '{1,4'hB,16'h0000}, '{1,4'h5,16'h0000}, '{1,4'h6,16'h4444}};

  prio_intc #(.NUM_SRC(16), .NUM_EXT(2)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin),
    .periph_evt(periph_evt), .trap_evt(trap_evt),
    .dma_trap_evt(dma_trap_evt), .loop_ovf_evt(loop_ovf_evt),
    .irq_ack(irq_ack), .level_load(level_load),
    .level_value(level_value), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level),
    .trap_req(trap_req), .current_cpu_level(current_cpu_level));
  core_model u_core (
    .sys_clk(sys_clk), .rst_n(rst_n), .irq_req(irq_req),
    .ack_en(ack_en), .ack_delay(ack_delay), .ret_req(ret_req),
    .ret_level(ret_level), .irq_ack(irq_ack),
    .level_load(level_load), .level_value(level_value));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and still reaches the report
  always @(posedge sys_clk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input word_t seen, input word_t exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input word_t d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input word_t exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wait_req(input logic exp);
    #1;
    for (int i = 0; i < 20 && irq_req !== exp; i++) cyc(1);
    chk({15'h0, irq_req}, {15'h0, exp});
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge sys_clk);
    periph_evt <= m;
    @(posedge sys_clk);
    periph_evt <= 14'h0000;
  endtask
  task automatic set_ack(input logic en, input logic [3:0] dly);
    @(posedge sys_clk);
    ack_en    <= en;
    ack_delay <= dly;
  endtask
  task automatic ret(input level_t l);
    @(posedge sys_clk);
    ret_req   <= 1'b1;
    ret_level <= l;
    @(posedge sys_clk);
    ret_req <= 1'b0;
  endtask
  task automatic chk_win(input logic [7:0] v, input level_t l);
    chk({8'h00, irq_vector}, {8'h00, v});
    chk({12'h000, irq_level}, {12'h000, l});
  endtask

  initial begin
    {rst_n, reg_wr, reg_rd, dma_trap_evt, loop_ovf_evt} = 5'h00;
    {ack_en, ret_req, reg_addr, trap_evt, ack_delay} = 14'h0000;
    {reg_wdata, periph_evt, ret_level, cyc_count} = '0;
    {err_count, n_checks} = '0;
    ext_irq_pin = 2'b10;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) begin
        wr(ROWS[i].a, ROWS[i].d);
      end else begin
        rdc(ROWS[i].a, ROWS[i].d);
      end
    end
    // one request walked through a take
    wr(4'h6, 16'h4544);
    wr(4'h5, 16'h0004);
    pulse(14'h0001);
    wait_req(1'b1);
    chk_win(8'h0A, 4'h5);
    set_ack(1'b1, 4'h0);
    wait_req(1'b0);
    rdc(4'hA, 16'h050A);
    rdc(4'hB, 16'h00A0);
    rdc(4'h4, 16'h0004);
    set_ack(1'b0, 4'h0);
    wr(4'h4, 16'h0004);
    rdc(4'h4, 16'h0000);
    // global enable gates, then a tie on priority 6
    ret(4'h0);
    wr(4'h1, 16'h0000);
    wr(4'h6, 16'h6344);
    wr(4'h7, 16'h4446);
    wr(4'h5, 16'h001C);
    pulse(14'h0007);
    cyc(4);
    chk({15'h0, irq_req}, 16'h0000);
    wr(4'h1, 16'h8000);
    wait_req(1'b1);
    chk_win(8'h0B, 4'h6);
    // current level equal to the priority blocks it
    wr(4'hB, 16'h00C0);
    wait_req(1'b0);
    wr(4'hB, 16'h0000);
    wr(4'h5, 16'h0014);
    cyc(2);
    wait_req(1'b1);
    chk_win(8'h0C, 4'h6);
    wr(4'h7, 16'h4440);
    cyc(3);
    chk_win(8'h0A, 4'h3);
    // nesting disable with a slow core
    wr(4'h0, 16'h8000);
    set_ack(1'b1, 4'h3);
    wait_req(1'b0);
    chk({12'h000, current_cpu_level}, 16'h0007);
    set_ack(1'b0, 4'h0);
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'hFFFF);
    wr(4'h5, 16'h0000);
    // trap flags and the soft hard trap
    @(posedge sys_clk);
    {dma_trap_evt, loop_ovf_evt, trap_evt} <= 6'h31;
    @(posedge sys_clk);
    {dma_trap_evt, loop_ovf_evt, trap_evt} <= 6'h00;
    rdc(4'h2, 16'h0003);
    rdc(4'h0, 16'h0001);
    chk({15'h0, trap_req}, 16'h0001);
    wr(4'h2, 16'h0003);
    wr(4'h0, 16'h000F);
    cyc(2);
    chk({15'h0, trap_req}, 16'h0000);
    wr(4'h3, 16'h0001);
    cyc(2);
    chk({15'h0, trap_req}, 16'h0001);
    wr(4'h3, 16'h0000);
    // top level bit only through the core
    ret(4'h8);
    rdc(4'hC, 16'h0008);
    rdc(4'hB, 16'h0000);
    wr(4'hB, 16'h00E0);
    rdc(4'hC, 16'h0008);
    chk({12'h000, current_cpu_level}, 16'h000F);
    ret(4'h0);
    // pin 0 rising, pin 1 falling
    wr(4'h5, 16'h0003);
    wr(4'h1, 16'h8002);
    @(posedge sys_clk);
    ext_irq_pin <= 2'b01;
    cyc(6);
    rdc(4'h4, 16'h0003);
    chk_win(8'h08, 4'h4);
    @(posedge sys_clk);
    ext_irq_pin <= 2'b00;
    cyc(6);
    // reset in mid-run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    cyc(2);
    chk({15'h0, irq_req}, 16'h0000);
    chk_win(8'h08, 4'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(4'h1, 16'h8000);
    rdc(4'h4, 16'h0000);
    end_of_test();
  end
endmodule
